// *** core/irq_pkg.sv ***
// Constants shared by the two-level interrupt handler.
package irq_pkg;
  localparam int NUM_SRC = 18;
  localparam int SRC_W = 5;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int VEC_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_BASIC_EN = 8'ha8;
  localparam logic [ADDR_W-1:0] ADDR_BASIC_PRI = 8'hb8;
  localparam logic [ADDR_W-1:0] ADDR_EXT_EN_ONE = 8'he6;
  localparam logic [ADDR_W-1:0] ADDR_EXT_EN_TWO = 8'he7;
  localparam logic [ADDR_W-1:0] ADDR_EXT_PRI_ONE = 8'hf6;
  localparam logic [ADDR_W-1:0] ADDR_EXT_PRI_TWO = 8'hf7;
  localparam int GLOBAL_EN_BIT = 7;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] BASIC_PRI_RESET = 8'h80;
  localparam logic [DATA_W-1:0] BASIC_PRI_RO_MASK = 8'h80;
  localparam logic [VEC_W-1:0] VEC_FIRST = 16'h0003;
  localparam int VEC_STRIDE_LOG2 = 3;
  // Sources whose pending flag the handler clears on vectoring.
  localparam logic [NUM_SRC-1:0] HW_CLEAR_MASK = 18'h0000f;
  localparam int DETECT_CYCLES = 1;
  localparam int RETURN_STEP_INSTRS = 1;
  typedef enum logic [1:0] {
    LVL_NONE = 2'b00,
    LVL_LOW = 2'b01,
    LVL_HIGH = 2'b11
  } level_e;
endpackage : irq_pkg

// *** core/two_level_interrupt_handler.sv ***
// Two-priority interrupt handler with eighteen sources and nesting.
// Functional notes
// - Eighteen sources, each at one of two levels.
// - Valid source event sets its pending flag.
// - Enabled pending flag requests vector long call.
// - Return instruction resumes interrupted flow; routines end so.
// - Flags set regardless; disabled flags raise nothing.
// - Per-source enable bits gate requests.
// - Source enables act only with global enable.
// - Global enable low blocks every source.
// - Blocked requests stay pending until global enable.
// - Some flags cleared on vectoring, others by software.
// - Flag still set after return re-enters routine.
// - Software writing one to flag acts as event.
// - Per-source priority bit; low after reset.
// - High preempts low; nothing preempts high.
// - Higher level first; fixed order breaks ties.
// - Requests sampled and decoded every clock cycle.
// - Equal or lower waits for return plus one instruction.
`timescale 1ns/10ps
`default_nettype none
module two_level_interrupt_handler (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [irq_pkg::NUM_SRC-1:0] src_event,
  input wire logic [irq_pkg::NUM_SRC-1:0] flag_set_sw,
  input wire logic [irq_pkg::NUM_SRC-1:0] flag_clr_sw,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [irq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [irq_pkg::DATA_W-1:0] reg_wdata,
  output logic [irq_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_hit,
  input wire logic instr_done,
  input wire logic return_from_interrupt_instr,
  input wire logic long_call_instr,
  output logic irq_req,
  output logic [irq_pkg::VEC_W-1:0] irq_vector,
  output logic [irq_pkg::SRC_W-1:0] irq_src,
  output logic [irq_pkg::NUM_SRC-1:0] pending,
  output logic [1:0] active_level
);
  import irq_pkg::*;

  function automatic logic [SRC_W:0] first_set(input logic [NUM_SRC-1:0] v);
    logic [SRC_W:0] r;
    r = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, SRC_W'(i)};
      end
    end
    return r;
  endfunction : first_set

  function automatic level_e level_of(input logic hi, input logic lo);
    level_e l;
    l = hi ? LVL_HIGH : (lo ? LVL_LOW : LVL_NONE);
    return l;
  endfunction : level_of

  // Mask of every source that ranks ahead of the given one in the fixed order.
  function automatic logic [NUM_SRC-1:0] below_mask(input logic [SRC_W-1:0] s);
    logic [NUM_SRC-1:0] m;
    m = (NUM_SRC'(1) << s) - NUM_SRC'(1);
    return m;
  endfunction : below_mask

  logic [DATA_W-1:0] basic_irq_enable_r;
  logic [DATA_W-1:0] basic_irq_priority_r;
  logic [DATA_W-1:0] ext_irq_enable_one_r;
  logic [DATA_W-1:0] ext_irq_enable_two_r;
  logic [DATA_W-1:0] ext_irq_priority_one_r;
  logic [DATA_W-1:0] ext_irq_priority_two_r;
  logic [NUM_SRC-1:0] pending_r;
  logic [NUM_SRC-1:0] pending_nxt;
  logic in_high_r;
  logic in_low_r;
  logic in_high_nxt;
  logic in_low_nxt;
  level_e active_level_r;
  logic hold_r;
  logic hold_nxt;
  logic irq_req_r;
  logic [SRC_W-1:0] irq_src_r;
  logic [VEC_W-1:0] irq_vector_r;
  logic [DATA_W-1:0] reg_rdata_r;
  logic reg_hit_r;

  wire logic global_irq_enable = basic_irq_enable_r[GLOBAL_EN_BIT];
  wire logic [NUM_SRC-1:0] src_enable = {ext_irq_enable_two_r[2:0], ext_irq_enable_one_r,
                                         basic_irq_enable_r[GLOBAL_EN_BIT-1:0]};
  wire logic [NUM_SRC-1:0] src_priority = {ext_irq_priority_two_r[2:0],
                                           ext_irq_priority_one_r,
                                           basic_irq_priority_r[GLOBAL_EN_BIT-1:0]};
  wire logic [NUM_SRC-1:0] armed = pending_r & src_enable
                                   & {NUM_SRC{global_irq_enable}};
  wire logic [NUM_SRC-1:0] armed_high = armed & src_priority;
  wire logic [NUM_SRC-1:0] armed_low = armed & ~src_priority;
  wire logic [SRC_W:0] pick_high = first_set(armed_high);
  wire logic [SRC_W:0] pick_low = first_set(armed_low);
  // A high request may interrupt low service; low requests need an idle core.
  wire logic high_ok = pick_high[SRC_W] && !in_high_r;
  wire logic low_ok = pick_low[SRC_W] && !in_high_r && !in_low_r;
  wire logic take_ok = (high_ok || low_ok) && !hold_r;
  wire logic [SRC_W-1:0] pick_src = high_ok ? pick_high[SRC_W-1:0] : pick_low[SRC_W-1:0];
  wire logic pick_is_high = high_ok;
  wire logic [VEC_W-1:0] pick_vec = VEC_FIRST + VEC_W'({pick_src, VEC_STRIDE_LOG2'(0)});
  wire logic call_taken = irq_req_r && long_call_instr;
  wire logic [NUM_SRC-1:0] call_clear = call_taken ?
      (HW_CLEAR_MASK & (NUM_SRC'(1) << irq_src_r)) : '0;
  // A return in the same cycle as a call pops no level but still starts the hold; the call wins.
  wire logic call_high = call_taken && src_priority[irq_src_r];
  wire logic call_low = call_taken && !src_priority[irq_src_r];
  wire logic ret_pop = return_from_interrupt_instr && !call_taken;
  wire logic wr_basic_en = reg_wr && reg_addr == ADDR_BASIC_EN;
  wire logic wr_basic_pri = reg_wr && reg_addr == ADDR_BASIC_PRI;
  wire logic wr_ext_en_one = reg_wr && reg_addr == ADDR_EXT_EN_ONE;
  wire logic wr_ext_en_two = reg_wr && reg_addr == ADDR_EXT_EN_TWO;
  wire logic wr_ext_pri_one = reg_wr && reg_addr == ADDR_EXT_PRI_ONE;
  wire logic wr_ext_pri_two = reg_wr && reg_addr == ADDR_EXT_PRI_TWO;
  wire logic addr_mapped = reg_addr == ADDR_BASIC_EN || reg_addr == ADDR_BASIC_PRI
                           || reg_addr == ADDR_EXT_EN_ONE || reg_addr == ADDR_EXT_EN_TWO
                           || reg_addr == ADDR_EXT_PRI_ONE || reg_addr == ADDR_EXT_PRI_TWO;
  wire logic [DATA_W-1:0] rd_mux =
      (reg_addr == ADDR_BASIC_EN) ? basic_irq_enable_r :
      (reg_addr == ADDR_BASIC_PRI) ? basic_irq_priority_r :
      (reg_addr == ADDR_EXT_EN_ONE) ? ext_irq_enable_one_r :
      (reg_addr == ADDR_EXT_EN_TWO) ? ext_irq_enable_two_r :
      (reg_addr == ADDR_EXT_PRI_ONE) ? ext_irq_priority_one_r :
      (reg_addr == ADDR_EXT_PRI_TWO) ? ext_irq_priority_two_r : REG_RESET;

  // Set beats clear so an event arriving with its clear is not lost.
  assign pending_nxt = (pending_r & ~flag_clr_sw & ~call_clear)
                       | src_event | flag_set_sw;
  // After a return at least one further instruction runs before a new request.
  assign hold_nxt = return_from_interrupt_instr ? 1'b1 : (instr_done ? 1'b0 : hold_r);
  assign in_high_nxt = call_high || (in_high_r && !ret_pop);
  assign in_low_nxt = call_low || (in_low_r && !(ret_pop && !in_high_r));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      basic_irq_enable_r <= REG_RESET;
      basic_irq_priority_r <= BASIC_PRI_RESET;
      ext_irq_enable_one_r <= REG_RESET;
      ext_irq_enable_two_r <= REG_RESET;
      ext_irq_priority_one_r <= REG_RESET;
      ext_irq_priority_two_r <= REG_RESET;
    end else begin
      if (wr_basic_en) basic_irq_enable_r <= reg_wdata;
      if (wr_basic_pri) basic_irq_priority_r <= reg_wdata | BASIC_PRI_RO_MASK;
      if (wr_ext_en_one) ext_irq_enable_one_r <= reg_wdata;
      if (wr_ext_en_two) ext_irq_enable_two_r <= reg_wdata;
      if (wr_ext_pri_one) ext_irq_priority_one_r <= reg_wdata;
      if (wr_ext_pri_two) ext_irq_priority_two_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_r <= REG_RESET;
      reg_hit_r <= 1'b0;
    end else begin
      reg_rdata_r <= reg_rd ? rd_mux : REG_RESET;
      reg_hit_r <= (reg_rd || reg_wr) && addr_mapped;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pending_r <= '0;
      hold_r <= 1'b0;
    end else begin
      pending_r <= pending_nxt;
      hold_r <= hold_nxt;
    end
  end

  // Request is re-evaluated every cycle until the core answers with the call.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_req_r <= 1'b0;
      irq_src_r <= '0;
      irq_vector_r <= '0;
    end else if (call_taken) begin
      irq_req_r <= 1'b0;
    end else begin
      irq_req_r <= take_ok;
      irq_src_r <= pick_src;
      irq_vector_r <= pick_vec;
    end
  end

  // The return leaves the innermost level; a high routine always sits on top.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      in_high_r <= 1'b0;
      in_low_r <= 1'b0;
      active_level_r <= LVL_NONE;
    end else begin
      in_high_r <= in_high_nxt;
      in_low_r <= in_low_nxt;
      // The level output is registered from the next state so it tracks the nesting flags.
      active_level_r <= level_of(in_high_nxt, in_low_nxt);
    end
  end

  assign irq_req = irq_req_r;
  assign irq_src = irq_src_r;
  assign irq_vector = irq_vector_r;
  assign pending = pending_r;
  assign active_level = active_level_r;
  assign reg_rdata = reg_rdata_r;
  assign reg_hit = reg_hit_r;

  property p_global_block;
    @(posedge clk_sys) disable iff (!reset_n)
      !global_irq_enable && !call_taken |=> !irq_req_r;
  endproperty
  a_global_block: assert property (p_global_block) else $error("request while blocked");

  property p_pending_kept;
    @(posedge clk_sys) disable iff (!reset_n)
      pending_r[0] && !flag_clr_sw[0] && !call_clear[0] |=> pending_r[0];
  endproperty
  a_pending_kept: assert property (p_pending_kept) else $error("pending flag lost");

  property p_event_sets;
    @(posedge clk_sys) disable iff (!reset_n)
      (src_event | flag_set_sw) != '0 |=> (pending_r & $past(src_event | flag_set_sw))
                                          == $past(src_event | flag_set_sw);
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("event did not set flag");

  property p_no_preempt_high;
    @(posedge clk_sys) disable iff (!reset_n)
      in_high_r && !call_taken |=> !irq_req_r;
  endproperty
  a_no_preempt_high: assert property (p_no_preempt_high) else $error("high preempted");

  property p_high_first;
    @(posedge clk_sys) disable iff (!reset_n)
      take_ok && pick_high[SRC_W] && !in_high_r && !call_taken |=> src_priority[irq_src_r];
  endproperty
  a_high_first: assert property (p_high_first) else $error("low chosen over high");

  sequence s_return;
    return_from_interrupt_instr ##1 (!instr_done)[*1];
  endsequence
  property p_hold_after_return;
    @(posedge clk_sys) disable iff (!reset_n)
      s_return |=> !irq_req_r;
  endproperty
  a_hold_after_return: assert property (p_hold_after_return) else $error("no gap after return");

  property p_request_fast;
    @(posedge clk_sys) disable iff (!reset_n)
      take_ok && !call_taken |=> irq_req_r;
  endproperty
  a_request_fast: assert property (p_request_fast) else $error("slow request");

  property p_disabled_silent;
    @(posedge clk_sys) disable iff (!reset_n)
      armed == '0 && !call_taken |=> !irq_req_r;
  endproperty
  a_disabled_silent: assert property (p_disabled_silent) else $error("disabled request");

  property p_vector_map;
    @(posedge clk_sys) disable iff (!reset_n)
      irq_req_r |-> irq_vector_r == VEC_FIRST + VEC_W'({irq_src_r, VEC_STRIDE_LOG2'(0)});
  endproperty
  a_vector_map: assert property (p_vector_map) else $error("wrong vector");

  property p_call_enters;
    @(posedge clk_sys) disable iff (!reset_n)
      call_taken |=> active_level_r != LVL_NONE;
  endproperty
  a_call_enters: assert property (p_call_enters) else $error("call left level idle");

  property p_return_pops;
    @(posedge clk_sys) disable iff (!reset_n)
      ret_pop && in_high_r |=> !in_high_r;
  endproperty
  a_return_pops: assert property (p_return_pops) else $error("return kept high level");

  property p_level_reg;
    @(posedge clk_sys) disable iff (!reset_n)
      active_level_r == level_of(in_high_r, in_low_r);
  endproperty
  a_level_reg: assert property (p_level_reg) else $error("level output out of step");

  // Only the sources in the hardware-clear set lose their flag on the call.
  property p_hw_clear;
    @(posedge clk_sys) disable iff (!reset_n)
      call_taken && HW_CLEAR_MASK[irq_src_r] && !src_event[irq_src_r]
      && !flag_set_sw[irq_src_r] |=> !pending_r[$past(irq_src_r)];
  endproperty
  a_hw_clear: assert property (p_hw_clear) else $error("flag not cleared on call");

  property p_sw_clear;
    @(posedge clk_sys) disable iff (!reset_n)
      (flag_clr_sw & ~src_event & ~flag_set_sw) != '0
      |=> (pending_r & $past(flag_clr_sw & ~src_event & ~flag_set_sw)) == '0;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("software clear lost");

  sequence s_pick_high;
    take_ok && !call_taken && pick_is_high;
  endsequence
  property p_tie_high;
    @(posedge clk_sys) disable iff (!reset_n)
      s_pick_high |=> (below_mask(irq_src_r) & $past(armed_high)) == '0;
  endproperty
  a_tie_high: assert property (p_tie_high) else $error("high tie order broken");

  sequence s_pick_low;
    take_ok && !call_taken && !pick_is_high;
  endsequence
  property p_tie_low;
    @(posedge clk_sys) disable iff (!reset_n)
      s_pick_low |=> (below_mask(irq_src_r) & $past(armed_low)) == '0;
  endproperty
  a_tie_low: assert property (p_tie_low) else $error("low tie order broken");

  property p_hold_blocks;
    @(posedge clk_sys) disable iff (!reset_n)
      hold_r |=> !irq_req_r;
  endproperty
  a_hold_blocks: assert property (p_hold_blocks) else $error("request inside return gap");

  property p_src_range;
    @(posedge clk_sys) disable iff (!reset_n)
      irq_req_r |-> irq_src_r < SRC_W'(NUM_SRC);
  endproperty
  a_src_range: assert property (p_src_range) else $error("source out of range");

  // Unmapped reads must return zero and no hit, so stray software sees nothing.
  property p_rd_unmapped;
    @(posedge clk_sys) disable iff (!reset_n)
      reg_rd && !addr_mapped |=> reg_rdata_r == REG_RESET && !reg_hit_r;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read answered");

  property p_pri_bit_fixed;
    @(posedge clk_sys) disable iff (!reset_n)
      basic_irq_priority_r[GLOBAL_EN_BIT];
  endproperty
  a_pri_bit_fixed: assert property (p_pri_bit_fixed) else $error("fixed priority bit low");
endmodule : two_level_interrupt_handler
`default_nettype wire

// *** test/cpu_core_model.sv ***
// Core-side model: steps instructions, takes vector calls, issues returns.
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic irq_req,
  input wire logic ack_en,
  input wire logic ret_cmd,
  output logic instr_done,
  output logic long_call_instr,
  output logic return_from_interrupt_instr
);
  logic [1:0] step_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      step_r <= 2'h0;
      instr_done <= 1'b0;
      long_call_instr <= 1'b0;
      return_from_interrupt_instr <= 1'b0;
    end else begin
      step_r <= step_r + 2'h1;
      // One slow instruction in four keeps completion off some cycles.
      instr_done <= (step_r != 2'h2);
      long_call_instr <= irq_req && ack_en && !long_call_instr;
      return_from_interrupt_instr <= ret_cmd && !return_from_interrupt_instr;
    end
  end
endmodule : cpu_core_model
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the two-level interrupt handler.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import irq_pkg::*;
  logic clk_sys, reset_n, reg_wr, reg_rd, reg_hit, done_i, ret_i, call_i, irq_req, ack_en, ret_cmd;
  logic [NUM_SRC-1:0] src_event, flag_set_sw, flag_clr_sw, pending;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [VEC_W-1:0] irq_vector;
  logic [SRC_W-1:0] irq_src;
  logic [1:0] active_level;
  int n_fail, n_tests;
  two_level_interrupt_handler dut (.clk_sys(clk_sys), .reset_n(reset_n), .src_event(src_event),
    .flag_set_sw(flag_set_sw), .flag_clr_sw(flag_clr_sw), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .instr_done(done_i), .return_from_interrupt_instr(ret_i), .long_call_instr(call_i),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_src(irq_src), .pending(pending),
    .active_level(active_level));
  cpu_core_model core (.clk_sys(clk_sys), .reset_n(reset_n), .irq_req(irq_req),
    .ack_en(ack_en), .ret_cmd(ret_cmd), .instr_done(done_i), .long_call_instr(call_i),
    .return_from_interrupt_instr(ret_i));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    @(negedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
    chk(reg_hit, hit);
    @(negedge clk_sys);
  endtask : rd
  task automatic pulse(input int kind, input logic [NUM_SRC-1:0] m);
    if (kind == 0) src_event = m;
    else if (kind == 1) flag_set_sw = m;
    else flag_clr_sw = m;
    @(negedge clk_sys);
    src_event = '0;
    flag_set_sw = '0;
    flag_clr_sw = '0;
  endtask : pulse
  task automatic want_req(input int s);
    int k;
    k = 0;
    while (irq_req !== 1'b1 && k < 8) begin
      @(negedge clk_sys);
      k++;
    end
    if (k == 8) begin
      n_fail++;
      give_verdict();
    end
    chk(irq_src, s);
    chk(irq_vector, 32'h3 + 32'(8 * s));
  endtask : want_req
  task automatic no_req(input int n);
    int seen;
    seen = 0;
    repeat (n) begin
      @(negedge clk_sys);
      if (irq_req !== 1'b0) seen++;
    end
    chk(seen, 0);
  endtask : no_req
  task automatic ack();
    ack_en = 1'b1;
    repeat (2) @(negedge clk_sys);
    ack_en = 1'b0;
    @(negedge clk_sys);
  endtask : ack
  task automatic ret();
    ret_cmd = 1'b1;
    @(negedge clk_sys);
    ret_cmd = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask : ret
  task automatic t_regs();
    rd(ADDR_BASIC_EN, 8'h00, 1'b1);
    rd(ADDR_BASIC_PRI, 8'h80, 1'b1);
    rd(ADDR_EXT_PRI_TWO, 8'h00, 1'b1);
    wr(ADDR_EXT_EN_ONE, 8'h5a);
    rd(ADDR_EXT_EN_ONE, 8'h5a, 1'b1);
    wr(ADDR_BASIC_PRI, 8'h04);
    rd(ADDR_BASIC_PRI, 8'h84, 1'b1);
    wr(8'h80, 8'hff);
    rd(8'h80, 8'h00, 1'b0);
    wr(ADDR_EXT_EN_ONE, 8'h00);
  endtask : t_regs
  task automatic t_mask();
    pulse(0, 18'h00020);
    no_req(4);
    chk(pending[5], 1'b1);
    wr(ADDR_BASIC_EN, 8'h20);
    no_req(4);
    wr(ADDR_BASIC_EN, 8'ha0);
    want_req(5);
    ack();
    chk(active_level, LVL_LOW);
    chk(pending[5], 1'b1);
    no_req(6);
    ret();
    want_req(5);
    ack();
    pulse(2, 18'h00020);
    ret();
    no_req(4);
    chk(active_level, LVL_NONE);
  endtask : t_mask
  task automatic t_nest();
    wr(ADDR_BASIC_EN, 8'h86);
    pulse(0, 18'h00006);
    want_req(2);
    ack();
    chk(active_level, LVL_HIGH);
    chk(pending[2], 1'b0);
    pulse(0, 18'h00004);
    no_req(6);
    ret();
    want_req(2);
    ack();
    ret();
    want_req(1);
    ack();
    pulse(0, 18'h00004);
    want_req(2);
    ack();
    ret();
    chk(active_level, LVL_LOW);
    ret();
    chk(active_level, LVL_NONE);
  endtask : t_nest
  task automatic t_tie();
    wr(ADDR_BASIC_EN, 8'hd1);
    pulse(0, 18'h00050);
    want_req(4);
    ack();
    chk(active_level, LVL_LOW);
    pulse(2, 18'h00050);
    ret();
    pulse(1, 18'h00001);
    want_req(0);
    ack();
    chk(pending[0], 1'b0);
    ret();
  endtask : t_tie
  initial begin
    reset_n = 1'b0;
    {reg_wr, reg_rd, ack_en, ret_cmd} = 4'h0;
    {src_event, flag_set_sw, flag_clr_sw} = '0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    t_regs();
    t_mask();
    t_nest();
    t_tie();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
